// ### rtl/cache_probe_regs.svh
`ifndef CACHE_PROBE_REGS_SVH
`define CACHE_PROBE_REGS_SVH

`define WB_DEPTH 3'h4
`define BURST_LAST 2'h3
`define STRAP_SETTLE 2'h2
`define TAG_MSB 31
`define TAG_LSB 12
`define TAG_LOW_REGISTER_NONTAG_W 8
`define DBR_RESET 1'b0

`endif

// ### rtl/cache_probe_pkg.sv
package cache_probe_pkg;
   typedef enum logic [1:0] {
      S_IDLE,
      S_WRITE,
      S_READ,
      S_DONE
   } bus_state_e;
   typedef logic [19:0] tag_t;
endpackage

// ### rtl/cache_probe_and_write_buffer.sv
`timescale 1ns/1ns
`include "cache_probe_regs.svh"

module cache_probe_and_write_buffer (
   input wire logic sys_clk, // processor clock
   input wire logic rstn, // async reset, active low
   input wire logic burst_strap, // refill burst strap pin
   input wire logic cfg_wr, // software write of burst bit
   input wire logic cfg_burst_val, // value written to burst bit
   input wire logic alternate_cache_split, // 1: 16K icache / 4K dcache
   input wire logic isolate_cache, // cache isolated
   output logic data_burst_refill, // active burst setting
   input wire logic st_valid, // store request
   input wire logic [31:0] st_addr, // store address
   input wire logic [31:0] st_data, // store data
   output logic st_ready, // store accepted (buffer not full)
   input wire logic ld_valid, // load request
   input wire logic ld_icache, // load targets instruction cache
   input wire logic ld_uncached, // load bypasses cache
   input wire logic [31:0] ld_addr, // load address
   output logic ld_ready, // load accepted
   output logic ld_done, // load complete pulse
   output logic ld_hit, // completed load hit in cache
   output logic [31:0] ld_data, // load data from memory
   output logic ld_stall, // core held for outstanding load
   output logic cache_miss_flag, // status miss flag
   input wire logic tag_rd_valid, // index tag-read operation
   input wire logic tag_rd_dcache, // 1: data cache, 0: instruction
   input wire logic [9:0] tag_rd_index, // line index
   output logic [31:0] tag_low_register, // tag read result
   output logic tag_low_valid, // tag read done pulse
   output logic refill_wr, // refill word strobe to data ram
   output logic refill_icache, // refill target cache
   output logic [31:0] refill_addr, // refill word address
   output logic [31:0] refill_data, // refill word
   output logic wb_empty, // write buffer empty
   output logic mem_req, // memory request, held until ack
   output logic mem_we, // memory write
   output logic mem_burst, // read is part of a 4-word burst
   output logic [31:0] mem_addr, // memory address
   output logic [31:0] mem_wdata, // memory write data
   input wire logic mem_ack, // memory completes one word
   input wire logic [31:0] mem_rdata // memory read data
);
   import cache_probe_pkg::*;

   // tag stores sized for the largest split of each cache
   tag_t itag [0:1023];
   tag_t dtag [0:511];
   logic [1023:0] ival_r;
   logic [511:0] dval_r;

   logic [31:0] wb_addr [0:3];
   logic [31:0] wb_data [0:3];
   logic [1:0] wb_wp_r;
   logic [1:0] wb_rp_r;
   logic [2:0] wb_cnt_r;

   bus_state_e state_r;
   logic ld_pend_r;
   logic ld_icache_r;
   logic ld_unc_r;
   logic [31:0] ld_addr_r;
   logic burst_r;
   logic [1:0] beat_r;
   logic strap_s1_r;
   logic strap_s2_r;
   logic [1:0] settle_r;
   logic strap_done_r;
   logic dbr_r;

   logic push;
   logic pop;
   logic ld_take;
   logic [9:0] i_idx;
   logic [8:0] d_idx;
   logic lk_hit;
   logic [9:0] r_i_idx;
   logic [8:0] r_d_idx;
   logic [31:0] rd_word_addr;

   assign data_burst_refill = dbr_r;

   // strap passes two flops, then is caught once it has settled
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         strap_s1_r <= 1'b0;
         strap_s2_r <= 1'b0;
      end else begin
         strap_s1_r <= burst_strap;
         strap_s2_r <= strap_s1_r;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         settle_r <= 2'h0;
         strap_done_r <= 1'b0;
         dbr_r <= `DBR_RESET;
      end else begin
         if (settle_r != `STRAP_SETTLE) begin
            settle_r <= settle_r + 2'h1;
         end
         if (cfg_wr) begin
            dbr_r <= cfg_burst_val;
            strap_done_r <= 1'b1;
         end else if (!strap_done_r && settle_r == `STRAP_SETTLE) begin
            dbr_r <= strap_s2_r;
            strap_done_r <= 1'b1;
         end
      end
   end

   // index width follows the split; unused top index bit is forced low
   always_comb begin
      if (alternate_cache_split) begin
         i_idx = ld_addr[13:4];
         d_idx = {1'b0, ld_addr[11:4]};
         r_i_idx = ld_addr_r[13:4];
         r_d_idx = {1'b0, ld_addr_r[11:4]};
      end else begin
         i_idx = {1'b0, ld_addr[12:4]};
         d_idx = ld_addr[12:4];
         r_i_idx = {1'b0, ld_addr_r[12:4]};
         r_d_idx = ld_addr_r[12:4];
      end
   end

   always_comb begin
      if (ld_icache) begin
         lk_hit = ival_r[i_idx] && itag[i_idx] == ld_addr[`TAG_MSB:`TAG_LSB];
      end else begin
         lk_hit = dval_r[d_idx] && dtag[d_idx] == ld_addr[`TAG_MSB:`TAG_LSB];
      end
   end

   // write buffer
   assign st_ready = wb_cnt_r != `WB_DEPTH;
   assign push = st_valid && st_ready;
   assign pop = state_r == S_WRITE && mem_ack;
   assign wb_empty = wb_cnt_r == 3'h0;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         wb_addr[wb_wp_r] <= st_addr;
         wb_data[wb_wp_r] <= st_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wb_wp_r <= 2'h0;
         wb_rp_r <= 2'h0;
         wb_cnt_r <= 3'h0;
      end else begin
         if (push) begin
            wb_wp_r <= wb_wp_r + 2'h1;
         end
         if (pop) begin
            wb_rp_r <= wb_rp_r + 2'h1;
         end
         if (push && !pop) begin
            wb_cnt_r <= wb_cnt_r + 3'h1;
         end else if (pop && !push) begin
            wb_cnt_r <= wb_cnt_r - 3'h1;
         end
      end
   end

   // one load outstanding; taken only when nothing is pending
   assign ld_take = ld_valid && !ld_pend_r && state_r != S_DONE;
   assign ld_ready = ld_take;
   assign ld_stall = ld_pend_r;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ld_pend_r <= 1'b0;
         ld_icache_r <= 1'b0;
         ld_unc_r <= 1'b0;
         ld_addr_r <= 32'h0;
         cache_miss_flag <= 1'b0;
         ld_hit <= 1'b0;
      end else begin
         if (ld_take) begin
            ld_icache_r <= ld_icache;
            ld_unc_r <= ld_uncached;
            ld_addr_r <= ld_addr;
            if (isolate_cache && !ld_uncached) begin
               cache_miss_flag <= !lk_hit;
               ld_hit <= lk_hit;
            end else if (!ld_uncached && lk_hit) begin
               ld_hit <= 1'b1;
            end else begin
               ld_pend_r <= 1'b1;
               ld_hit <= 1'b0;
            end
         end else if (state_r == S_DONE) begin
            ld_pend_r <= 1'b0;
         end
      end
   end

   // done pulses one cycle after a lookup hit or isolated probe, or at refill end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ld_done <= 1'b0;
      end else begin
         ld_done <= (ld_take && (isolate_cache || lk_hit) && !ld_uncached)
                    || state_r == S_DONE;
      end
   end

   // bus sequencer: writes always win over reads
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= S_IDLE;
         burst_r <= 1'b0;
         beat_r <= 2'h0;
      end else begin
         case (state_r)
            S_IDLE: begin
               if (!wb_empty) begin
                  state_r <= S_WRITE;
               end else if (ld_pend_r) begin
                  state_r <= S_READ;
                  // burst length sampled per miss, so a change applies next miss
                  burst_r <= !ld_unc_r && (ld_icache_r || dbr_r);
                  beat_r <= 2'h0;
               end
            end
            S_WRITE: begin
               if (mem_ack) begin
                  state_r <= S_IDLE;
               end
            end
            S_READ: begin
               if (mem_ack) begin
                  if (!burst_r || beat_r == `BURST_LAST) begin
                     state_r <= S_DONE;
                  end
                  beat_r <= beat_r + 2'h1;
               end
            end
            S_DONE: begin
               state_r <= S_IDLE;
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   assign rd_word_addr = burst_r ? {ld_addr_r[31:4], beat_r, 2'h0} : ld_addr_r;

   always_comb begin
      mem_req = 1'b0;
      mem_we = 1'b0;
      mem_burst = 1'b0;
      mem_addr = 32'h0;
      mem_wdata = 32'h0;
      case (state_r)
         S_WRITE: begin
            mem_req = 1'b1;
            mem_we = 1'b1;
            mem_addr = wb_addr[wb_rp_r];
            mem_wdata = wb_data[wb_rp_r];
         end
         S_READ: begin
            mem_req = 1'b1;
            mem_burst = burst_r;
            mem_addr = rd_word_addr;
         end
         default: begin
            mem_req = 1'b0;
         end
      endcase
   end

   // refill words and captured load data
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         refill_wr <= 1'b0;
         refill_icache <= 1'b0;
         refill_addr <= 32'h0;
         refill_data <= 32'h0;
         ld_data <= 32'h0;
      end else begin
         refill_wr <= state_r == S_READ && mem_ack && !ld_unc_r;
         if (state_r == S_READ && mem_ack) begin
            refill_icache <= ld_icache_r;
            refill_addr <= rd_word_addr;
            refill_data <= mem_rdata;
            if (rd_word_addr[31:2] == ld_addr_r[31:2]) begin
               ld_data <= mem_rdata;
            end
         end
      end
   end

   // tags are written when a cached refill finishes; a one-word refill
   // still marks the whole line valid, per-word validity is not tracked
   always_ff @(posedge sys_clk) begin
      if (state_r == S_DONE && !ld_unc_r) begin
         if (ld_icache_r) begin
            itag[r_i_idx] <= ld_addr_r[`TAG_MSB:`TAG_LSB];
         end else begin
            dtag[r_d_idx] <= ld_addr_r[`TAG_MSB:`TAG_LSB];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ival_r <= '0;
         dval_r <= '0;
      end else if (state_r == S_DONE && !ld_unc_r) begin
         if (ld_icache_r) begin
            ival_r[r_i_idx] <= 1'b1;
         end else begin
            dval_r[r_d_idx] <= 1'b1;
         end
      end
   end

   // tag probe; bit 0 of the 12-bit non-tag field carries the valid bit
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tag_low_register <= 32'h0;
         tag_low_valid <= 1'b0;
      end else begin
         tag_low_valid <= tag_rd_valid;
         if (tag_rd_valid) begin
            if (tag_rd_dcache) begin
               tag_low_register <= {dtag[{tag_rd_index[8] && !alternate_cache_split,
                                          tag_rd_index[7:0]}], 4'h0, 7'h00,
                                    dval_r[{tag_rd_index[8] && !alternate_cache_split,
                                            tag_rd_index[7:0]}]};
            end else begin
               tag_low_register <= {itag[{tag_rd_index[9] && alternate_cache_split,
                                          tag_rd_index[8:0]}], 4'h0, 7'h00,
                                    ival_r[{tag_rd_index[9] && alternate_cache_split,
                                            tag_rd_index[8:0]}]};
            end
         end
      end
   end

endmodule

// ### bench/cache_probe_props.sv
`timescale 1ns/1ns
module cache_probe_props (
   input wire logic sys_clk, // clock
   input wire logic rstn, // reset
   input wire logic cfg_wr, // burst write
   input wire logic cfg_burst_val, // burst value
   input wire logic isolate_cache, // isolated
   input wire logic data_burst_refill, // burst bit
   input wire logic st_valid, // store
   input wire logic st_ready, // store taken
   input wire logic ld_valid, // load
   input wire logic ld_uncached, // uncached
   input wire logic ld_ready, // load taken
   input wire logic ld_done, // load done
   input wire logic ld_hit, // hit
   input wire logic ld_stall, // stall
   input wire logic cache_miss_flag, // miss flag
   input wire logic tag_rd_valid, // probe
   input wire logic [31:0] tag_low_register, // probe result
   input wire logic tag_low_valid, // probe done
   input wire logic wb_empty, // buffer empty
   input wire logic mem_req, // bus request
   input wire logic mem_we, // bus write
   input wire logic [31:0] mem_addr, // bus address
   input wire logic mem_ack // bus ack
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   a_write_first: assert property (mem_req && !mem_we |-> wb_empty)
      else $error("read issued with writes pending");
   a_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("bus request dropped before ack");
   a_probe_answer: assert property (tag_rd_valid |=> tag_low_valid
      && tag_low_register[11:1] == 11'h000)
      else $error("tag probe answer wrong");
   a_isolated_flag: assert property (ld_valid && ld_ready && isolate_cache && !ld_uncached
      |=> ld_done && cache_miss_flag == !ld_hit)
      else $error("isolated load flag wrong");
   a_cfg_apply: assert property (cfg_wr |=> data_burst_refill == $past(cfg_burst_val))
      else $error("burst bit not written");
   a_uncached_stall: assert property (ld_valid && ld_ready && ld_uncached |=> ld_stall)
      else $error("uncached load did not stall");
   a_store_kept: assert property (st_valid && st_ready |=> !wb_empty)
      else $error("store not buffered");
   a_stall_blocks: assert property (ld_stall |-> !ld_ready)
      else $error("load taken while stalled");
   a_stall_drain: assert property (ld_stall && !wb_empty |=> ld_stall)
      else $error("stall released with writes pending");
   a_done_pulse: assert property (ld_done |=> !ld_done)
      else $error("load done longer than a cycle");
   c_full: cover property (st_valid && !st_ready);
   c_burst_read: cover property (mem_req && !mem_we && data_burst_refill);
   c_iso_miss: cover property (ld_done && cache_miss_flag);
endmodule
bind cache_probe_and_write_buffer cache_probe_props i_props (.*);

// ### bench/mem_model.sv
`timescale 1ns/1ns
module mem_model (
   input wire logic sys_clk, // clock
   input wire logic rstn, // reset
   input wire logic [3:0] lat, // wait cycles before ack
   input wire logic mem_req, // request
   input wire logic [31:0] mem_addr, // address
   output logic mem_ack, // one-cycle ack
   output logic [31:0] mem_rdata // read word
);
   logic [3:0] cnt_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 4'h0;
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
      end else begin
         mem_ack <= 1'b0;
         // stale data flips so it never passes for a fresh word
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            if (cnt_r >= lat) begin
               mem_ack <= 1'b1;
               mem_rdata <= ~mem_addr;
               cnt_r <= 4'h0;
            end else begin
               cnt_r <= cnt_r + 4'h1;
            end
         end
      end
   end
endmodule

// ### bench/tb_cache_probe_and_write_buffer.sv
`timescale 1ns/1ns
module tb_cache_probe_and_write_buffer;
   logic sys_clk = 0, rstn = 0, burst_strap = 1, cfg_wr = 0, cfg_burst_val = 0;
   logic alternate_cache_split = 1, isolate_cache = 0, st_valid = 0, ld_valid = 0;
   logic ld_icache = 0, ld_uncached = 0, tag_rd_valid = 0, tag_rd_dcache = 1;
   logic [31:0] st_addr = 0, st_data = 0, ld_addr = 0;
   logic [9:0] tag_rd_index = 0;
   logic [3:0] lat = 0;
   logic data_burst_refill, st_ready, ld_ready, ld_done, ld_hit, ld_stall, cache_miss_flag;
   logic tag_low_valid, refill_wr, refill_icache, wb_empty, mem_req, mem_we, mem_burst, mem_ack;
   logic [31:0] ld_data, tag_low_register, refill_addr, refill_data, mem_addr, mem_wdata;
   logic [31:0] mem_rdata;
   logic [31:0] wq[$];
   int miscompares = 0, checked = 0, rd = 0, brd = 0, fills = 0, full = 0;
   cache_probe_and_write_buffer i_dut (.*);
   mem_model i_mem (.*);
   initial forever #5 sys_clk = ~sys_clk;
   // comb outputs settle mid-cycle, so the bus is watched on the falling edge
   always @(negedge sys_clk) begin
      if (mem_req && mem_ack && mem_we) begin
         wq.push_back(mem_addr);
         chk("write data", ~mem_addr, mem_wdata);
      end
      if (mem_req && mem_ack && !mem_we) begin
         rd++;
         if (mem_burst) brd++;
      end
      if (refill_wr) begin
         fills++;
         chk("refill data", ~refill_addr, refill_data);
      end
      if (st_valid && !st_ready) full++;
   end
   task summarize;
      $display("checks %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task tmo;
      miscompares++;
      summarize();
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   task store(input logic [31:0] a);
      int i;
      st_valid <= 1'b1;
      st_addr <= a;
      st_data <= ~a;
      for (i = 0; i < 100; i++) begin
         @(negedge sys_clk);
         if (st_ready) break;
      end
      if (i == 100) tmo();
      @(posedge sys_clk);
   endtask
   task cfg(input logic v);
      @(posedge sys_clk);
      cfg_wr <= 1'b1;
      cfg_burst_val <= v;
      @(posedge sys_clk);
      cfg_wr <= 1'b0;
      @(negedge sys_clk);
   endtask
   task load(input logic [31:0] a, input logic u, input logic ic);
      int i;
      // raised on a rising edge, so ld_ready is judged before the taking edge
      @(posedge sys_clk);
      ld_valid <= 1'b1;
      ld_addr <= a;
      ld_uncached <= u;
      ld_icache <= ic;
      rd = 0;
      brd = 0;
      fills = 0;
      for (i = 0; i < 100; i++) begin
         @(negedge sys_clk);
         if (ld_ready) break;
      end
      if (i == 100) tmo();
      @(posedge sys_clk);
      ld_valid <= 1'b0;
      for (i = 0; i < 300; i++) begin
         @(negedge sys_clk);
         if (ld_done) break;
      end
      if (i == 300) tmo();
      @(posedge sys_clk);
   endtask
   task probe(input logic [9:0] ix, input logic dc);
      @(posedge sys_clk);
      tag_rd_valid <= 1'b1;
      tag_rd_index <= ix;
      tag_rd_dcache <= dc;
      @(posedge sys_clk);
      tag_rd_valid <= 1'b0;
      @(negedge sys_clk);
   endtask
   initial begin
      // split chosen before any cache use, so no reinit is needed
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chk("strap burst", 32'h1, 32'(data_burst_refill));
      cfg(1'b0);
      chk("sw override", 32'h0, 32'(data_burst_refill));
      load(32'h0000_3010, 1'b0, 1'b0);
      chk("single beats", 32'h1, 32'(rd));
      chk("single flag", 32'h0, 32'(brd));
      chk("single fill", 32'h1, 32'(fills));
      chk("miss data", ~32'h0000_3010, ld_data);
      isolate_cache <= 1'b1;
      // miss first, so a flag that only holds its last value cannot pass the hit check
      load(32'h0000_5010, 1'b0, 1'b0);
      chk("iso miss flag", 32'h1, 32'(cache_miss_flag));
      chk("iso miss hit", 32'h0, 32'(ld_hit));
      load(32'h0000_3010, 1'b0, 1'b0);
      chk("iso hit flag", 32'h0, 32'(cache_miss_flag));
      chk("iso no bus", 32'h0, 32'(rd));
      isolate_cache <= 1'b0;
      // with the small data cache bit 12 is tag, so the line sits at index 1
      probe(10'h001, 1'b1);
      chk("probe tag", 32'h0000_3001, tag_low_register);
      cfg(1'b1);
      load(32'h0000_4024, 1'b0, 1'b0);
      chk("burst beats", 32'h4, 32'(rd));
      chk("burst flag", 32'h4, 32'(brd));
      chk("burst data", ~32'h0000_4024, ld_data);
      load(32'h0000_402C, 1'b0, 1'b0);
      chk("hit no bus", 32'h0, 32'(rd));
      chk("hit flag", 32'h1, 32'(ld_hit));
      lat <= 4'h6;
      for (int k = 0; k < 6; k++) store(32'h100 + 32'(4 * k));
      st_valid <= 1'b0;
      @(negedge sys_clk);
      chk("buffered", 32'h0, 32'(wb_empty));
      chk("full stall", 32'h1, 32'(full > 0));
      load(32'h0000_0F00, 1'b1, 1'b0);
      chk("writes drained", 32'h6, 32'(wq.size()));
      chk("uncached data", ~32'h0000_0F00, ld_data);
      chk("flushed", 32'h1, 32'(wb_empty));
      foreach (wq[k]) chk("write order", 32'h100 + 32'(4 * k), wq[k]);
      // a reset stands in for the reinit that a split change needs
      rstn <= 1'b0;
      alternate_cache_split <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      load(32'h0000_1010, 1'b0, 1'b0);
      chk("strap burst again", 32'h4, 32'(rd));
      chk("even split data", ~32'h0000_1010, ld_data);
      load(32'h0000_2040, 1'b0, 1'b1);
      chk("icache fill", 32'h4, 32'(fills));
      chk("icache target", 32'h1, 32'(refill_icache));
      chk("icache data", ~32'h0000_2040, ld_data);
      probe(10'h101, 1'b1);
      chk("even split dtag", 32'h0000_1001, tag_low_register);
      probe(10'h004, 1'b0);
      chk("itag probe", 32'h0000_2001, tag_low_register);
      summarize();
   end
endmodule
